// ---- core/prio_irq_device.sv ----
`default_nettype none
// What this block does
// RULE1: Eight active-low requests, line 7 ranks highest.
// RULE2: Simultaneous requests: only highest one is taken.
// RULE3: Accepted request latched; three-bit code presented.
// RULE4: Vector code is complement of level.
// RULE5: Code fits restart opcode bits five to three.
// RULE6: Refused requesters keep their line asserted.
// RULE7: Condition gate needs all five enabling terms.
// RULE8: Interrupt asserts on next clock after gate.
// RULE9: Interrupt sets disable; no more until cleared.
// RULE10: Status strobe low clears disable, writes status.
// RULE11: Interrupt lasts one clock; processor latches it.
// RULE12: Shared interrupt line sets every device's disable.
// RULE13: Processor writes serviced level complemented.
// RULE14: Only strictly higher than status is accepted.
// RULE15: Compare select low on strobe disables compare.
// RULE16: Accept only while group enable input high.
// RULE17: Group enable out high when nothing pending.
// RULE18: Level read enable low enables the device.
// RULE19: Open-collector outputs with separate drive enables.
module prio_irq_device
   import prio_irq_pkg::*;
(
   input  wire logic               i_clock,
   input  wire logic               i_nrst,
   prio_link_if.dev_end            link,
   output var  logic               o_pending,
   output var  logic [LEVEL_W-1:0] o_latched_level,
   output var  logic               o_int_disable,
   output var  logic               o_compare_on
);
   // Width of the bundle of pin inputs that pass the synchroniser
   localparam int unsigned SYNC_W = NUM_REQ + LEVEL_W + 6;
   // Idle pin levels, so reset does not look like activity
   localparam logic [SYNC_W-1:0] SYNC_IDLE = 17'h1FFF5;

   logic [SYNC_W-1:0]  sync1_q;
   logic [SYNC_W-1:0]  sync2_q;
   logic [NUM_REQ-1:0] s_req_n;
   logic [LEVEL_W-1:0] s_lvl_n;
   logic               s_sgs;
   logic               s_strobe_n;
   logic               s_gate;
   logic               s_lre_n;
   logic               s_ge_in;
   logic               s_int_n;
   logic               strobe_prev_q;
   logic               status_write;
   logic [LEVEL_W-1:0] cs_level_q;
   logic               cmp_on_q;
   logic [3:0]         pick;
   logic               any_req;
   logic [LEVEL_W-1:0] req_level;
   logic               outranks;
   logic               cond;
   logic               int_q;
   logic               disable_q;
   logic               lat_valid_q;
   logic [LEVEL_W-1:0] lat_level_q;
   logic [LEVEL_W-1:0] vec_oe_q;
   logic               ge_out_q;

   // Highest active request wins; bit 3 flags that any is active
   function automatic logic [3:0] pick_highest(
      input logic [NUM_REQ-1:0] active
   );
      logic [3:0] r;
      r = 4'h0;
      for (int i = 0; i < NUM_REQ; i++)
      begin
         if (active[i])
            r = {1'b1, 3'(i)};
      end
      return r;
   endfunction

   // Every pin passes two flops; nothing reads the first stage
   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         sync1_q <= SYNC_IDLE;
         sync2_q <= SYNC_IDLE;
      end
      else
      begin
         sync1_q <= {link.request_lines_n, link.status_level_in_n,
                     link.status_compare_sel, link.status_write_strobe_n,
                     link.interrupt_gate_in, link.level_read_enable_n,
                     link.group_enable_in, link.int_line_n};
         sync2_q <= sync1_q;
      end
   end

   // Unpack the synchronised pins
   assign s_req_n    = sync2_q[SYNC_W-1 -: NUM_REQ];
   assign s_lvl_n    = sync2_q[8:6];
   assign s_sgs      = sync2_q[5];
   assign s_strobe_n = sync2_q[4];
   assign s_gate     = sync2_q[3];
   assign s_lre_n    = sync2_q[2];
   assign s_ge_in    = sync2_q[1];
   assign s_int_n    = sync2_q[0];

   // Status write happens on the falling edge of the strobe
   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
         strobe_prev_q <= 1'b1;
      else
         strobe_prev_q <= s_strobe_n;
   end
   assign status_write = strobe_prev_q & ~s_strobe_n;

   // Current status register: level arrives complemented on the pins
   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         cs_level_q <= CS_LEVEL_RESET;
         cmp_on_q   <= CMP_ON_RESET;
      end
      else if (status_write)
      begin
         cs_level_q <= ~s_lvl_n; // RULE10
         cmp_on_q   <= s_sgs; // RULE15
      end
   end

   // Priority encoder over the active-low request lines
   assign pick      = pick_highest(~s_req_n); // RULE1 RULE2
   assign any_req   = pick[3];
   assign req_level = pick[LEVEL_W-1:0];

   // Strictly higher than the status level, unless compare is off
   assign outranks = ~cmp_on_q | (req_level > cs_level_q); // RULE14

   // Condition gate feeding the interrupt flop
   assign cond = s_ge_in & s_gate & ~s_lre_n & any_req // RULE7 RULE16 RULE18
               & outranks & ~disable_q; // RULE7

   // Interrupt flop: cond drops once disable is set, so one period only
   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
         int_q <= 1'b0;
      else
         int_q <= cond; // RULE8 RULE11
   end

   // Disable flop: own interrupt or any interrupt on the shared line
   // sets it; a set in the same cycle as a status write wins
   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
         disable_q <= 1'b0;
      else if (cond || !s_int_n)
         disable_q <= 1'b1; // RULE9 RULE12
      else if (status_write)
         disable_q <= 1'b0; // RULE10
   end

   // Request latch: only accepted requests are kept, others must persist
   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         lat_valid_q <= 1'b0;
         lat_level_q <= 3'h0;
      end
      else if (cond)
      begin
         lat_valid_q <= 1'b1; // RULE3
         lat_level_q <= req_level; // RULE3
      end
      else if (status_write)
         lat_valid_q <= 1'b0;
   end

   // Vector lines pull low where the complemented code has a zero, so
   // the wire level is the complement of the level and lands straight
   // in opcode bits five to three; it appears with the interrupt
   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
         vec_oe_q <= 3'h0;
      else if (cond)
         vec_oe_q <= req_level; // RULE4 RULE5 RULE19
      else if (lat_valid_q && !s_lre_n && s_ge_in)
         vec_oe_q <= lat_level_q; // RULE4 RULE18
      else
         vec_oe_q <= 3'h0; // RULE19
   end

   // Next group is enabled only when this one has nothing pending
   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
         ge_out_q <= 1'b0;
      else
         ge_out_q <= s_ge_in & ~any_req & ~lat_valid_q; // RULE17
   end

   // Open-collector drive: value always low, enable pulls the wire down
   assign link.vector_drv       = 3'h0;
   assign link.vector_oe        = vec_oe_q; // RULE19
   assign link.int_drv          = 1'b0;
   assign link.int_oe           = int_q; // RULE19
   assign link.group_enable_out = ge_out_q;

   // User-side status, from flops
   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_pending       <= 1'b0;
         o_latched_level <= 3'h0;
         o_int_disable   <= 1'b0;
         o_compare_on    <= 1'b0;
      end
      else
      begin
         o_pending       <= lat_valid_q;
         o_latched_level <= lat_level_q;
         o_int_disable   <= disable_q;
         o_compare_on    <= cmp_on_q;
      end
   end
endmodule
`default_nettype wire

// ---- core/prio_irq_host.sv ----
`default_nettype none
module prio_irq_host
   import prio_irq_pkg::*;
(
   input  wire logic        i_clock,
   input  wire logic        i_nrst,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output var  logic [31:0] o_prdata,
   output var  logic        o_pready,
   output var  logic        o_pslverr,
   output var  logic        o_irq,
   prio_link_if.host_end    link
);
   logic [4:0]         sync1_q, sync2_q;
   logic               gout_prev_q, int_prev_q;
   logic [2:0]         ctrl_q;
   logic [NUM_REQ-1:0] req_q;
   logic [3:0]         stw_q;
   logic [1:0]         ev_q, mask_q;
   logic [7:0]         opcode_q;
   stb_state_t         state_q;
   logic [3:0]         cnt_q;
   logic               busy, access, stall, wr, int_fall, gout_fall;

   // Wire levels from the device pass two flops before use
   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         // Group enable out idles low in reset, so its stages start low:
         // a high start would log a false fall right after release
         sync1_q <= 5'h1E;
         sync2_q <= 5'h1E;
         int_prev_q <= 1'b1;
         gout_prev_q <= 1'b0;
      end
      else
      begin
         sync1_q <= {link.int_line_n, link.vector_code_out,
                     link.group_enable_out};
         sync2_q <= sync1_q;
         int_prev_q <= sync2_q[4];
         gout_prev_q <= sync2_q[0];
      end
   end

   // The pulse lasts one period, so it is caught in a sticky bit here
   assign int_fall  = int_prev_q & ~sync2_q[4]; // RULE11
   assign gout_fall = gout_prev_q & ~sync2_q[0];
   assign busy   = (state_q != ST_IDLE);
   assign access = i_psel & i_penable & ~o_pready;
   // A status write during a running strobe waits instead of being lost
   assign stall  = i_pwrite & (i_paddr == REG_STATUS_WR) & busy;
   // A write lands at the edge where the master sees pready high
   assign wr     = i_psel & i_penable & o_pready & i_pwrite;

   // APB answer: one wait state, registered data and error
   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata  <= 32'h0;
      end
      else
      begin
         o_pready  <= access & ~stall;
         o_pslverr <= 1'b0;
         o_prdata  <= 32'h0;
         if (access & ~stall)
         begin
            if (i_paddr == REG_CTRL)
               o_prdata <= {29'h0, ctrl_q};
            else if (i_paddr == REG_REQUEST)
               o_prdata <= {24'h0, req_q};
            else if (i_paddr == REG_STATUS_WR)
               o_prdata <= {23'h0, busy, 4'h0, stw_q};
            else if (i_paddr == REG_IRQ_STAT)
               o_prdata <= {30'h0, ev_q};
            else if (i_paddr == REG_IRQ_MASK)
               o_prdata <= {30'h0, mask_q};
            else if (i_paddr == REG_VECTOR)
               o_prdata <= {22'h0, ~sync2_q[4], sync2_q[0], opcode_q};
            else
               o_pslverr <= 1'b1;
         end
      end
   end

   // Software registers; a set event beats a write-one clear
   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         ctrl_q   <= CTRL_RESET;
         req_q    <= 8'h00;
         mask_q   <= 2'h0;
         ev_q     <= 2'h0;
         opcode_q <= RST_FRAME;
         o_irq    <= 1'b0;
      end
      else
      begin
         if (wr && i_paddr == REG_CTRL)
            ctrl_q <= i_pwdata[2:0];
         // Requests stay asserted until software withdraws them
         if (wr && i_paddr == REG_REQUEST)
            req_q <= i_pwdata[7:0]; // RULE6
         if (wr && i_paddr == REG_IRQ_MASK)
            mask_q <= i_pwdata[1:0];
         ev_q <= (ev_q & ~((wr && i_paddr == REG_IRQ_STAT) ?
                  i_pwdata[1:0] : 2'h0)) | {gout_fall, int_fall};
         if (int_fall)
            opcode_q <= RST_FRAME | ({5'h0, sync2_q[3:1]} << RST_CODE_LSB);
         o_irq <= |(ev_q & mask_q);
      end
   end

   // Status write sequencer: data set up, strobe low, data held
   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         state_q <= ST_IDLE;
         cnt_q   <= 4'h0;
         stw_q   <= 4'h0;
      end
      else
      begin
         cnt_q <= cnt_q - 4'h1;
         case (state_q)
            ST_IDLE:
               if (wr && i_paddr == REG_STATUS_WR)
               begin
                  stw_q   <= i_pwdata[3:0];
                  state_q <= ST_SETUP;
                  cnt_q   <= 4'(STB_SETUP_CYC - 1);
               end
            ST_SETUP:
               if (cnt_q == 4'h0)
               begin
                  state_q <= ST_LOW;
                  cnt_q   <= 4'(STB_PULSE_CYC - 1);
               end
            ST_LOW:
               if (cnt_q == 4'h0)
               begin
                  state_q <= ST_HOLD;
                  cnt_q   <= 4'(STB_HOLD_CYC - 1);
               end
            default:
               if (cnt_q == 4'h0)
                  state_q <= ST_IDLE;
         endcase
      end
   end

   // Pin drive, all from flops
   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         link.request_lines_n       <= 8'hFF;
         link.status_level_in_n     <= 3'h7;
         link.status_compare_sel    <= 1'b0;
         link.status_write_strobe_n <= 1'b1;
         link.interrupt_gate_in     <= 1'b0;
         link.level_read_enable_n   <= 1'b1;
         link.group_enable_in       <= 1'b0;
      end
      else
      begin
         link.request_lines_n       <= ~req_q;
         // Serviced level goes out complemented
         link.status_level_in_n     <= ~stw_q[2:0]; // RULE13
         link.status_compare_sel    <= stw_q[STW_CMP_BIT];
         // Every device is cleared by the one shared strobe
         link.status_write_strobe_n <= (state_q != ST_LOW); // RULE10 RULE12
         link.interrupt_gate_in     <= ctrl_q[CTRL_GATE_BIT];
         link.level_read_enable_n   <= ctrl_q[CTRL_LRD_BIT];
         link.group_enable_in       <= ctrl_q[CTRL_GROUP_BIT];
      end
   end
endmodule
`default_nettype wire

// ---- core/prio_irq_pkg.sv ----
`default_nettype none
package prio_irq_pkg;
   // Request level and vector code widths
   localparam int unsigned LEVEL_W = 3;
   localparam int unsigned NUM_REQ = 8;

   // Clock and pin timing, converted to cycles (least times round up)
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned STB_SETUP_NS  = 15;
   localparam int unsigned STB_PULSE_NS  = 25;
   localparam int unsigned STB_HOLD_NS   = 15;
   localparam int unsigned STB_SETUP_CYC =
      (STB_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned STB_PULSE_CYC =
      (STB_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned STB_HOLD_CYC =
      (STB_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Restart opcode frame: ones at 7,6,2,1,0, code at 5..3
   localparam logic [7:0] RST_FRAME   = 8'hC7;
   localparam int unsigned RST_CODE_LSB = 3;

   // Host register offsets (byte addresses, one word each)
   localparam logic [7:0] REG_CTRL      = 8'h00;
   localparam logic [7:0] REG_REQUEST   = 8'h04;
   localparam logic [7:0] REG_STATUS_WR = 8'h08;
   localparam logic [7:0] REG_IRQ_STAT  = 8'h0C;
   localparam logic [7:0] REG_IRQ_MASK  = 8'h10;
   localparam logic [7:0] REG_VECTOR    = 8'h14;

   // Control register fields and reset values
   localparam int unsigned CTRL_GATE_BIT  = 0;
   localparam int unsigned CTRL_LRD_BIT   = 1;
   localparam int unsigned CTRL_GROUP_BIT = 2;
   localparam logic [2:0]  CTRL_RESET     = 3'h5;

   // Status write fields, event bits and readback bits
   localparam int unsigned STW_CMP_BIT   = 3;
   localparam int unsigned STW_BUSY_BIT  = 8;
   localparam int unsigned EV_INT_BIT    = 0;
   localparam int unsigned EV_GROUP_BIT  = 1;
   localparam int unsigned VEC_GOUT_BIT  = 8;
   localparam int unsigned VEC_INT_BIT   = 9;

   // Device-side reset values
   localparam logic [LEVEL_W-1:0] CS_LEVEL_RESET = 3'h0;
   localparam logic               CMP_ON_RESET   = 1'b0;

   // Host strobe sequencer
   typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_LOW, ST_HOLD} stb_state_t;
endpackage
`default_nettype wire

// ---- core/prio_link_if.sv ----
`default_nettype none
interface prio_link_if;
   import prio_irq_pkg::*;
   logic [NUM_REQ-1:0] request_lines_n;
   logic [LEVEL_W-1:0] status_level_in_n;
   logic               status_compare_sel;
   logic               status_write_strobe_n;
   logic               interrupt_gate_in;
   logic               level_read_enable_n;
   logic               group_enable_in;
   logic               group_enable_out;
   // Open-collector lines: drive value is always low, enable pulls down
   logic [LEVEL_W-1:0] vector_drv;
   logic [LEVEL_W-1:0] vector_oe;
   logic               int_drv;
   logic               int_oe;
   // Resolved wire levels with the pull-up
   logic [LEVEL_W-1:0] vector_code_out;
   logic               int_line_n;
   assign vector_code_out = ~vector_oe | vector_drv;
   assign int_line_n      = ~int_oe | int_drv;

   modport dev_end (
      input  request_lines_n, status_level_in_n, status_compare_sel,
      input  status_write_strobe_n, interrupt_gate_in, level_read_enable_n,
      input  group_enable_in, vector_code_out, int_line_n,
      output group_enable_out, vector_drv, vector_oe, int_drv, int_oe
   );
   modport host_end (
      output request_lines_n, status_level_in_n, status_compare_sel,
      output status_write_strobe_n, interrupt_gate_in, level_read_enable_n,
      output group_enable_in,
      input  group_enable_out, vector_code_out, int_line_n
   );
endinterface
`default_nettype wire

// ---- testbench/eight_level_priority_interrupt_ctrl_bench.sv ----
`default_nettype none
module eight_level_priority_interrupt_ctrl_bench
   import prio_irq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic [2:0] ctrl;
      logic [3:0] stw;
      logic [7:0] req;
      logic       acc;
      logic       mask;
   } trial_t;

   localparam trial_t ROWS [8] = '{
      '{3'h5, 4'hF, 8'h80, 1'b0, 1'b1},
      '{3'h5, 4'hE, 8'h80, 1'b1, 1'b1},
      '{3'h5, 4'hD, 8'h10, 1'b0, 1'b1},
      '{3'h5, 4'h5, 8'h10, 1'b1, 1'b1},
      '{3'h4, 4'h0, 8'h04, 1'b0, 1'b1},
      '{3'h7, 4'h0, 8'h04, 1'b0, 1'b1},
      '{3'h1, 4'h0, 8'h04, 1'b0, 1'b1},
      '{3'h5, 4'hA, 8'h0C, 1'b1, 1'b1}};

   logic        clock;
   logic        nrst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        irq;
   logic        pending;
   logic [2:0]  latched_level;
   logic        int_disable;
   logic        compare_on;
   int          errors;
   int          samples_checked;
   int          seed;
   logic [32:0] expect_q[$];

   prio_link_if link ();

   prio_irq_host u_prio_irq_host (
      .i_clock(clock), .i_nrst(nrst), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .o_irq(irq), .link(link));
   prio_irq_device u_prio_irq_device (
      .i_clock(clock), .i_nrst(nrst), .link(link), .o_pending(pending),
      .o_latched_level(latched_level), .o_int_disable(int_disable),
      .o_compare_on(compare_on));
   prio_irq_chk u_prio_irq_chk (
      .i_clock(clock), .i_nrst(nrst),
      .request_lines_n(link.request_lines_n),
      .status_write_strobe_n(link.status_write_strobe_n),
      .interrupt_gate_in(link.interrupt_gate_in),
      .level_read_enable_n(link.level_read_enable_n),
      .group_enable_in(link.group_enable_in),
      .group_enable_out(link.group_enable_out),
      .vector_drv(link.vector_drv), .vector_oe(link.vector_oe),
      .int_drv(link.int_drv), .int_oe(link.int_oe),
      .vector_code_out(link.vector_code_out));

   // Free-running 200 MHz clock
   initial
   begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   task automatic close_out();
      if (errors == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic cmp(input logic [32:0] got, input logic [32:0] want);
      samples_checked++;
      if (got !== want)
      begin
         errors++;
         $display("wrong value at %0t ns: got %h, expected %h",
                  $time, got, want);
      end
   endtask

   // Holds the request until pready; the slave sets its own wait states
   task automatic bus(input logic wr, input logic [7:0] addr,
                      input logic [31:0] data);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= addr;
      pwdata  <= data;
      @(posedge clock);
      penable <= 1'b1;
      do
         @(posedge clock);
      while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask

   task automatic wr(input logic [7:0] addr, input logic [31:0] data);
      bus(1'b1, addr, data);
   endtask

   task automatic rd(input logic [7:0] addr, input logic [32:0] want);
      expect_q.push_back(want);
      bus(1'b0, addr, 32'h0);
   endtask

   // Read answers are judged against the oldest note at the pready edge
   always @(posedge clock)
   begin
      if (psel && penable && !pwrite && pready === 1'b1)
         cmp({pslverr, prdata},
             expect_q.size() > 0 ? expect_q.pop_front() : {33{1'bx}});
   end

   // One request pattern under one set of enables and status
   task automatic trial(input trial_t t);
      logic [2:0] lvl;
      lvl = 3'h0;
      for (int i = 0; i < 8; i++)
         if (t.req[i])
            lvl = i[2:0];
      wr(REG_REQUEST, 32'h0);
      wr(REG_CTRL, {29'h0, t.ctrl});
      wr(REG_IRQ_MASK, {31'h0, t.mask});
      wr(REG_STATUS_WR, {28'h0, t.stw});
      wr(REG_IRQ_STAT, 32'h3);
      wr(REG_REQUEST, {24'h0, t.req});
      repeat (20) @(posedge clock);
      rd(REG_IRQ_STAT, {31'h0, t.ctrl[CTRL_GROUP_BIT], t.acc});
      cmp({32'h0, irq}, {32'h0, t.acc & t.mask});
      cmp({32'h0, compare_on}, {32'h0, t.stw[STW_CMP_BIT]});
      if (t.acc)
      begin
         cmp({28'h0, pending, int_disable, latched_level},
             {28'h0, 2'h3, lvl});
         rd(REG_VECTOR, {25'h0, RST_FRAME | {2'h0, ~lvl, 3'h0}});
      end
      wr(REG_IRQ_STAT, 32'h3);
      rd(REG_IRQ_STAT, 33'h0);
      cmp({32'h0, irq}, 33'h0);
   endtask

   // Cuts a hung run short well past the expected thousand or so cycles
   initial
   begin
      #300000;
      errors++;
      close_out();
   end

   initial
   begin
      logic [7:0] lvl_req;
      errors = 0;
      samples_checked = 0;
      seed = 32'h23C9;
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (6) @(posedge clock);
      nrst <= 1'b1;
      @(posedge clock);
      rd(REG_CTRL, {30'h0, CTRL_RESET});
      rd(REG_IRQ_MASK, 33'h0);
      rd(REG_IRQ_STAT, 33'h0);
      rd(REG_STATUS_WR, 33'h0);
      rd(REG_VECTOR, {24'h0, 1'b1, RST_FRAME});
      rd(8'h18, {1'b1, 32'h0});
      cmp({31'h0, pending, compare_on}, 33'h0);
      // Every level in turn, with random lower requests beside it
      for (int l = 0; l < 8; l++)
      begin
         lvl_req = (8'h01 << l) | (8'($random(seed)) & ((8'h01 << l) - 8'h01));
         trial('{3'h5, 4'h0, lvl_req, 1'b1, (l != 3)});
      end
      foreach (ROWS[r])
         trial(ROWS[r]);
      // Level 3 still latched: a higher request must wait for a status write
      wr(REG_REQUEST, 32'h8C);
      repeat (20) @(posedge clock);
      rd(REG_IRQ_STAT, 33'h0);
      cmp({30'h0, latched_level}, 33'h3);
      // Back-to-back status writes: the second waits out the first strobe
      wr(REG_REQUEST, 32'h0);
      wr(REG_STATUS_WR, 32'h7);
      wr(REG_STATUS_WR, 32'hE);
      rd(REG_STATUS_WR, {24'h0, 1'b1, 8'h0E});
      close_out();
   end
endmodule
`default_nettype wire

// ---- testbench/prio_irq_chk.sv ----
`default_nettype none
module prio_irq_chk
   import prio_irq_pkg::*;
(
   input  wire logic               i_clock,
   input  wire logic               i_nrst,
   input  wire logic [NUM_REQ-1:0] request_lines_n,
   input  wire logic               status_write_strobe_n,
   input  wire logic               interrupt_gate_in,
   input  wire logic               level_read_enable_n,
   input  wire logic               group_enable_in,
   input  wire logic               group_enable_out,
   input  wire logic [LEVEL_W-1:0] vector_drv,
   input  wire logic [LEVEL_W-1:0] vector_oe,
   input  wire logic               int_drv,
   input  wire logic               int_oe,
   input  wire logic [LEVEL_W-1:0] vector_code_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_nrst);

   logic armed_q;

   // Remembers an interrupt until the status strobe re-arms the device
   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
         armed_q <= 1'b0;
      else if (!status_write_strobe_n)
         armed_q <= 1'b0;
      else if (int_oe)
         armed_q <= 1'b1;
   end

   // Highest asserted request, written apart from the design's encoder
   function automatic logic [LEVEL_W-1:0] top_level(
      input logic [NUM_REQ-1:0] req_n);
      top_level = '0;
      for (int i = 0; i < NUM_REQ; i++)
         if (!req_n[i])
            top_level = i[LEVEL_W-1:0];
   endfunction

   // Input pins see a two-flop sync, so five samples leave margin
   sequence s_chip_off;
      level_read_enable_n [*5];
   endsequence
   sequence s_group_off;
      !group_enable_in [*5];
   endsequence

   property p_int_pulse;
      int_oe |=> !int_oe;
   endproperty
   property p_no_retrigger;
      int_oe |-> !armed_q;
   endproperty
   property p_gate;
      int_oe |-> $past(interrupt_gate_in, 3) && $past(group_enable_in, 3)
                 && !$past(level_read_enable_n, 3);
   endproperty
   property p_vector;
      int_oe |-> vector_code_out == ~top_level($past(request_lines_n, 3));
   endproperty
   property p_group_out;
      int_oe |-> !group_enable_out;
   endproperty
   property p_chip_off;
      s_chip_off |-> vector_oe == '0 && !int_oe;
   endproperty
   property p_group_off;
      s_group_off |-> vector_oe == '0 && !int_oe;
   endproperty
   property p_strobe_clear;
      $fell(status_write_strobe_n) |-> ##[2:4] (vector_oe == '0);
   endproperty
   property p_open_drain;
      vector_drv == '0 && !int_drv;
   endproperty

   a_int_pulse: assert property (p_int_pulse)
      else $error("interrupt pulse longer than one cycle");
   a_no_retrigger: assert property (p_no_retrigger)
      else $error("second interrupt before status write");
   a_gate: assert property (p_gate)
      else $error("interrupt without all enabling terms");
   a_vector: assert property (p_vector)
      else $error("vector code not complement of top level");
   a_group_out: assert property (p_group_out)
      else $error("group enable out high while pending");
   a_chip_off: assert property (p_chip_off)
      else $error("device active while level read disabled");
   a_group_off: assert property (p_group_off)
      else $error("device active while group disabled");
   a_strobe_clear: assert property (p_strobe_clear)
      else $error("status write left the request latched");
   a_open_drain: assert property (p_open_drain)
      else $error("open drain line driven high");
endmodule
`default_nettype wire
